// ===== src/ldsi_consts.svh
// Named constants for the loop DAC serial input logic.
`ifndef LDSI_CONSTS_SVH
`define LDSI_CONSTS_SVH

`define LDSI_WORD_W 16
`define LDSI_CNT_W 9
`define LDSI_HALF_CELL 4'h8
`define LDSI_FIRST_SAMPLE 9'h018
`define LDSI_STOP_SAMPLE 9'h118
`define LDSI_BOTTOM_CODE 16'h0000
`define LDSI_SPAN_RST 2'h0

`endif

// ===== src/ldsi_pkg.sv
// Types shared by the loop DAC serial input logic.
package ldsi_pkg;

	typedef enum logic [1:0] {
		LDSI_SPAN_V0_5,
		LDSI_SPAN_MA4_20,
		LDSI_SPAN_MA0_20,
		LDSI_SPAN_MA0_24
	} ldsi_span_t;

	typedef enum logic {
		LDSI_RX_IDLE,
		LDSI_RX_FRAME
	} ldsi_rx_state_t;

endpackage

// ===== src/ldsi_async_rx.sv
// Framed asynchronous receiver, running on the serial data clock.
`timescale 1ns/1ps
`include "ldsi_consts.svh"

module ldsi_async_rx (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic async_mode_in,
	input wire logic data_in,
	output logic [15:0] word_out,
	output logic done_toggle_out,
	output logic frame_err_out
);

	ldsi_pkg::ldsi_rx_state_t state_reg;
	logic [`LDSI_CNT_W-1:0] cnt_reg;
	logic [15:0] shift_reg;
	logic data_prev_reg;
	logic start_seen;
	logic bit_sample;
	logic stop_sample;

	assign start_seen = (state_reg == ldsi_pkg::LDSI_RX_IDLE) && async_mode_in &&
		data_prev_reg && !data_in;
	assign bit_sample = (state_reg == ldsi_pkg::LDSI_RX_FRAME) &&
		(cnt_reg[3:0] == `LDSI_HALF_CELL) && (cnt_reg >= `LDSI_FIRST_SAMPLE) &&
		(cnt_reg < `LDSI_STOP_SAMPLE);
	assign stop_sample = (state_reg == ldsi_pkg::LDSI_RX_FRAME) &&
		(cnt_reg == `LDSI_STOP_SAMPLE);
	assign frame_err_out = stop_sample && !data_in;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			data_prev_reg <= 1'b1;
		else
			data_prev_reg <= data_in;
	end

	// The counter names the clock of the frame: 0 is the first clock after the falling edge.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			state_reg <= ldsi_pkg::LDSI_RX_IDLE;
			cnt_reg <= '0;
		end
		else if (start_seen)
		begin
			state_reg <= ldsi_pkg::LDSI_RX_FRAME;
			cnt_reg <= '0;
		end
		else if (stop_sample)
			state_reg <= ldsi_pkg::LDSI_RX_IDLE;
		else if (state_reg == ldsi_pkg::LDSI_RX_FRAME)
			cnt_reg <= cnt_reg + 1'b1;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			shift_reg <= '0;
		else if (bit_sample)
			shift_reg <= {shift_reg[14:0], data_in};
	end

	// The word is held until the next stop bit sampled 1, which gives the other domain ample time to read it.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			word_out <= `LDSI_BOTTOM_CODE;
			done_toggle_out <= 1'b0;
		end
		else if (stop_sample && data_in)
		begin
			word_out <= shift_reg;
			done_toggle_out <= !done_toggle_out;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_start_count: assert property (@(posedge clk_in) disable iff (rst_in)
		start_seen |=> (state_reg == ldsi_pkg::LDSI_RX_FRAME) && (cnt_reg == '0))
		else $error("frame did not start after falling edge");
	a_msb_sample: assert property (@(posedge clk_in) disable iff (rst_in)
		(state_reg == ldsi_pkg::LDSI_RX_FRAME) && (cnt_reg == `LDSI_FIRST_SAMPLE)
		|=> shift_reg[0] == $past(data_in))
		else $error("msb not sampled at clock 24");
	a_stop_load: assert property (@(posedge clk_in) disable iff (rst_in)
		stop_sample && data_in |=> (done_toggle_out != $past(done_toggle_out)) &&
		(word_out == $past(shift_reg)))
		else $error("good stop bit did not deliver the word");
	a_err_discard: assert property (@(posedge clk_in) disable iff (rst_in)
		frame_err_out |=> $stable(done_toggle_out) && $stable(word_out))
		else $error("word delivered despite framing error");
	a_back_idle: assert property (@(posedge clk_in) disable iff (rst_in)
		stop_sample |=> state_reg == ldsi_pkg::LDSI_RX_IDLE)
		else $error("receiver not idle after stop bit");

endmodule

// ===== src/ldsi_top.sv
// Top of the loop DAC serial input logic: three-wire shifter, receiver and output word.
// How it works
// - Force-bottom input high drives the output code to span bottom, any span.
// - Two span pins, high then low, pick 0-5 V, 4-20, 0-20, 0-24 mA.
// - Asynchronous frames open with a 0 start bit and close with a 1 stop bit.
// - Asynchronous bits are sampled on the clock edge at each cell centre.
// - Cells last 16 clocks; start cell begins one clock after the falling edge.
// - Most significant bit sampled at clock 24, next at 40, then every 16.
// - A received word reaches the output when its stop bit is sampled.
// - A stop bit sampled 0 gives a one-clock high pulse on serial output.
// - On a framing error the output is unchanged and the word discarded.
// - Strobe rising edge loads the shift register; strobe tied high is asynchronous.
// - Force-bottom leaves the shift register alone; bottom holds until next update.
// - Three-wire serial output carries bits leaving the shift register, for chaining.
`timescale 1ns/1ps
`include "ldsi_consts.svh"

module ldsi_top (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic link_clk_in,
	input wire logic data_in,
	input wire logic load_strobe_in,
	input wire logic force_bottom_in,
	input wire logic [1:0] span_sel_in,
	output logic serial_out,
	output logic [15:0] code_out,
	output logic [1:0] span_out,
	output logic at_bottom_out
);

	// ****************************************
	// Link clock domain
	// ****************************************
	logic rst_link_meta_reg;
	logic rst_link_reg;
	logic [15:0] shift_reg;
	logic [15:0] rx_word;
	logic rx_toggle;
	logic rx_frame_err;

	// Reset reaches the link side through two flops; the link clock must run during reset.
	always_ff @(posedge link_clk_in)
	begin
		rst_link_meta_reg <= rst_in;
		rst_link_reg <= rst_link_meta_reg;
	end

	// Shifting stops while the strobe is high, so a tied-high strobe freezes this register.
	always_ff @(posedge link_clk_in)
	begin
		if (rst_link_reg)
			shift_reg <= `LDSI_BOTTOM_CODE;
		else if (!load_strobe_in)
			shift_reg <= {shift_reg[14:0], data_in};
	end

	always_ff @(posedge link_clk_in)
	begin
		if (rst_link_reg)
			serial_out <= 1'b0;
		else if (load_strobe_in)
			serial_out <= rx_frame_err;
		else
			serial_out <= shift_reg[15];
	end

	ldsi_async_rx u_rx (
		.clk_in(link_clk_in),
		.rst_in(rst_link_reg),
		.async_mode_in(load_strobe_in),
		.data_in(data_in),
		.word_out(rx_word),
		.done_toggle_out(rx_toggle),
		.frame_err_out(rx_frame_err)
	);

	// ****************************************
	// System clock domain
	// ****************************************
	logic strobe_meta_reg;
	logic strobe_sync_reg;
	logic strobe_prev_reg;
	logic tog_meta_reg;
	logic tog_sync_reg;
	logic tog_prev_reg;
	logic clear_meta_reg;
	logic clear_sync_reg;
	logic [1:0] span_meta_reg;
	ldsi_pkg::ldsi_span_t span_reg;
	logic strobe_rise;
	logic rx_done;
	logic [15:0] code_next;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			strobe_meta_reg <= 1'b1;
			strobe_sync_reg <= 1'b1;
			strobe_prev_reg <= 1'b1;
		end
		else
		begin
			strobe_meta_reg <= load_strobe_in;
			strobe_sync_reg <= strobe_meta_reg;
			strobe_prev_reg <= strobe_sync_reg;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			tog_meta_reg <= 1'b0;
			tog_sync_reg <= 1'b0;
			tog_prev_reg <= 1'b0;
		end
		else
		begin
			tog_meta_reg <= rx_toggle;
			tog_sync_reg <= tog_meta_reg;
			tog_prev_reg <= tog_sync_reg;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			clear_meta_reg <= 1'b0;
			clear_sync_reg <= 1'b0;
			span_meta_reg <= `LDSI_SPAN_RST;
			span_reg <= ldsi_pkg::ldsi_span_t'(`LDSI_SPAN_RST);
		end
		else
		begin
			clear_meta_reg <= force_bottom_in;
			clear_sync_reg <= clear_meta_reg;
			span_meta_reg <= span_sel_in;
			span_reg <= ldsi_pkg::ldsi_span_t'(span_meta_reg);
		end
	end

	assign strobe_rise = strobe_sync_reg && !strobe_prev_reg;
	assign rx_done = tog_sync_reg != tog_prev_reg;

	// The shift register is read without its own synchroniser: it is still when the strobe
	// rises because the host holds the clock low around the strobe.
	always_comb
	begin
		code_next = code_out;
		if (clear_sync_reg)
			code_next = `LDSI_BOTTOM_CODE;
		else if (strobe_rise)
			code_next = shift_reg;
		else if (rx_done)
			code_next = rx_word;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			code_out <= `LDSI_BOTTOM_CODE;
		else
			code_out <= code_next;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			at_bottom_out <= 1'b1;
		else if (clear_sync_reg)
			at_bottom_out <= 1'b1;
		else if (strobe_rise || rx_done)
			at_bottom_out <= 1'b0;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			span_out <= `LDSI_SPAN_RST;
		else
			span_out <= span_reg;
	end

	// ****************************************
	// Checks
	// ****************************************
	a_clear_bottom: assert property (@(posedge clk_in) disable iff (rst_in)
		clear_sync_reg |=> (code_out == `LDSI_BOTTOM_CODE) && at_bottom_out)
		else $error("force-bottom did not reach span bottom");
	a_bottom_hold: assert property (@(posedge clk_in) disable iff (rst_in)
		at_bottom_out && !strobe_rise && !rx_done |=> code_out == `LDSI_BOTTOM_CODE)
		else $error("output left bottom without an update");
	a_span_follow: assert property (@(posedge clk_in) disable iff (rst_in)
		1'b1 |-> ##3 span_out == $past(span_sel_in, 3))
		else $error("span output does not follow span pins");
	a_strobe_load: assert property (@(posedge clk_in) disable iff (rst_in)
		strobe_rise && !clear_sync_reg |=> code_out == $past(shift_reg))
		else $error("strobe edge did not load the shift register");
	a_shift_in: assert property (@(posedge link_clk_in) disable iff (rst_link_reg)
		!load_strobe_in |=> shift_reg == {$past(shift_reg[14:0]), $past(data_in)})
		else $error("shift register did not take the serial bit");
	a_chain_out: assert property (@(posedge link_clk_in) disable iff (rst_link_reg)
		!load_strobe_in |=> serial_out == $past(shift_reg[15]))
		else $error("serial output is not the bit leaving the register");
	a_err_pulse: assert property (@(posedge link_clk_in) disable iff (rst_link_reg)
		load_strobe_in && rx_frame_err ##1 load_strobe_in |-> serial_out ##1 !serial_out)
		else $error("framing error pulse not exactly one clock");
	a_strobe_freeze: assert property (@(posedge link_clk_in) disable iff (rst_link_reg)
		load_strobe_in |=> $stable(shift_reg))
		else $error("shift register moved while the strobe was high");

endmodule

// ===== verification/ldsi_host_model.sv
// Host model that drives the serial clock, data line and load strobe.
`timescale 1ns/1ps

module ldsi_host_model (
	output logic link_clk_out,
	output logic data_out,
	output logic strobe_out
);
	int frame_edge = 0;

	initial
	begin
		link_clk_out = 1'b0;
		data_out = 1'b1;
		strobe_out = 1'b1;
	end

	// One link period; data moves only while the clock is low.
	task automatic tick(input logic d);
		data_out = d;
		#6 link_clk_out = 1'b1;
		#6 link_clk_out = 1'b0;
	endtask

	task automatic idle(input int n);
		for (int i = 0; i < n; i++)
			tick(1'b1);
	endtask

	task automatic shift_bits(input logic [31:0] w, input int n);
		strobe_out = 1'b0;
		for (int b = n - 1; b >= 0; b--)
			tick(w[b]);
		data_out = ~w[0];
	endtask

	// The clock stays low around the strobe so the word is quiet when crossed.
	// The low time spans several system clocks, so the synchroniser cannot miss it.
	task automatic load_pulse();
		strobe_out = 1'b0;
		#60 strobe_out = 1'b1;
		#100;
	endtask

	// Data bits are right only next to each cell centre, as a slow host may leave them.
	// After the stop-bit sample the line keeps the stop level to the end of the cell, then idles high, so no false start follows.
	task automatic async_frame(input logic [15:0] w, input logic stop_bit);
		logic [16:0] cells;
		int pos;
		logic flip;
		cells = {w, stop_bit};
		strobe_out = 1'b1;
		for (int i = -2; i < 292; i++)
		begin
			frame_edge = i;
			pos = (i - 16) % 16;
			flip = (i < 281) && (pos < 8 || pos > 10);
			if (i < 0 || i > 287)
				tick(1'b1);
			else if (i < 16)
				tick(1'b0);
			else
				tick(cells[16 - (i - 16) / 16] ^ flip);
		end
	endtask
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the loop DAC serial input logic.
`timescale 1ns/1ps

module testbench;
	typedef struct {logic [15:0] word; logic [1:0] span;} ldsi_row_t;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic force_bottom_in = 1'b0;
	logic [1:0] span_sel_in = 2'h0;
	logic link_clk, data_line, strobe, serial_out, at_bottom_out;
	logic [15:0] code_out;
	logic [1:0] span_out;
	logic [31:0] chain_q = 32'h0;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	int pulse_cnt = 0;
	int pulse_at = 0;
	ldsi_row_t rows [4] = '{'{16'hFFFF, 2'h0}, '{16'h8001, 2'h1}, '{16'h1234, 2'h2},
		'{16'hA5C3, 2'h3}};
	logic [15:0] fr_word [3] = '{16'hC35A, 16'h0FF0, 16'h8421};
	logic fr_stop [3] = '{1'b1, 1'b0, 1'b1};
	logic [15:0] fr_code [3] = '{16'hC35A, 16'hC35A, 16'h8421};

	always #10 clk_in = ~clk_in;

	ldsi_top u_ldsi_top (.clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk),
		.data_in(data_line), .load_strobe_in(strobe), .force_bottom_in(force_bottom_in),
		.span_sel_in(span_sel_in), .serial_out(serial_out), .code_out(code_out),
		.span_out(span_out), .at_bottom_out(at_bottom_out));

	ldsi_host_model u_ldsi_host_model (.link_clk_out(link_clk), .data_out(data_line),
		.strobe_out(strobe));

	always @(posedge link_clk)
	begin
		if (strobe === 1'b0)
			chain_q = {chain_q[30:0], serial_out};
		else if (serial_out === 1'b1)
		begin
			pulse_cnt++;
			pulse_at = u_ldsi_host_model.frame_edge;
		end
	end

	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			err_total++;
			give_verdict();
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// The link clock runs during reset, since the link side resets only through its own flops.
	task automatic do_reset();
		#1 rst_in = 1'b1;
		fork
			u_ldsi_host_model.idle(9);
			repeat (5) @(posedge clk_in);
		join
		@(posedge clk_in);
		#1 rst_in = 1'b0;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		do_reset();
		u_ldsi_host_model.idle(6);
		check(code_out, 16'h0000);
		check({15'h0, at_bottom_out}, 16'h0001);
		foreach (rows[r])
		begin
			@(posedge clk_in);
			#1 span_sel_in = rows[r].span;
			u_ldsi_host_model.shift_bits({16'h0, rows[r].word}, 16);
			u_ldsi_host_model.load_pulse();
			check(code_out, rows[r].word);
			check({14'h0, span_out}, {14'h0, rows[r].span});
			check({15'h0, at_bottom_out}, 16'h0000);
		end
		// Two words back to back: the first must come out of the chain port.
		u_ldsi_host_model.shift_bits(32'h5A3C_9F06, 32);
		u_ldsi_host_model.load_pulse();
		check({chain_q[14:0], serial_out}, 16'h5A3C);
		check(code_out, 16'h9F06);
		@(posedge clk_in);
		#1 force_bottom_in = 1'b1;
		repeat (4) @(posedge clk_in);
		#1 check(code_out, 16'h0000);
		check({15'h0, at_bottom_out}, 16'h0001);
		u_ldsi_host_model.load_pulse();
		check(code_out, 16'h0000);
		@(posedge clk_in);
		#1 force_bottom_in = 1'b0;
		repeat (4) @(posedge clk_in);
		#1 check(code_out, 16'h0000);
		check({15'h0, at_bottom_out}, 16'h0001);
		u_ldsi_host_model.load_pulse();
		check(code_out, 16'h9F06);
		check({15'h0, at_bottom_out}, 16'h0000);
		for (int f = 0; f < 3; f++)
		begin
			pulse_cnt = 0;
			u_ldsi_host_model.async_frame(fr_word[f], fr_stop[f]);
			#100;
			check(code_out, fr_code[f]);
			check(pulse_cnt[15:0], {15'h0, ~fr_stop[f]});
			if (!fr_stop[f])
				check(pulse_at[15:0], 16'h011A);
		end
		// A second reset in mid-run brings the output back to the bottom of the span.
		@(posedge clk_in);
		do_reset();
		check(code_out, 16'h0000);
		check({15'h0, at_bottom_out}, 16'h0001);
		check({14'h0, span_out}, 16'h0000);
		u_ldsi_host_model.idle(6);
		check({14'h0, span_out}, {14'h0, rows[3].span});
		check({15'h0, serial_out}, 16'h0000);
		give_verdict();
	end
endmodule
